// *** uart_mcsb_pkg.sv ***
package uart_mcsb_pkg;
  // register selects on the three address lines
  localparam logic [2:0] ADDR_HOLD = 3'h0;
  localparam logic [2:0] ADDR_INT_ENABLE = 3'h1;
  localparam logic [2:0] ADDR_INT_ID = 3'h2;
  localparam logic [2:0] ADDR_LCR = 3'h3;
  localparam logic [2:0] ADDR_MODEM_CONTROL = 3'h4;
  localparam logic [2:0] ADDR_LINE_STATUS = 3'h5;
  localparam logic [2:0] ADDR_MODEM_STATUS = 3'h6;
  localparam logic [2:0] ADDR_SCR = 3'h7;
  localparam logic [2:0] ADDR_DIV_LOW = 3'h0;
  localparam logic [2:0] ADDR_DIV_HIGH = 3'h1;
  // field positions
  localparam int HOLDING_EMPTY_BIT = 5;
  localparam int ALL_EMPTY_BIT = 6;
  localparam int DIV_ACCESS_BIT = 7;
  localparam int CTRL_DTR_BIT = 0;
  localparam int CTRL_RTS_BIT = 1;
  localparam int CTRL_USER_ONE_BIT = 2;
  localparam int CTRL_USER_TWO_BIT = 3;
  localparam int CTRL_LOOP_BIT = 4;
  localparam int EN_HOLDING_BIT = 1;
  localparam int EN_MODEM_BIT = 3;
  localparam int RING_BIT = 2;
  // reset values
  localparam logic [4:0] CTRL_RESET = 5'h00;
  localparam logic [3:0] INT_EN_RESET = 4'h0;
  localparam logic [7:0] LCR_RESET = 8'h00;
  localparam logic [7:0] SCR_RESET = 8'h00;
  localparam logic [15:0] DIVISOR_RESET = 16'h0000;
  // identification codes
  localparam logic [7:0] ID_NONE = 8'h01;
  localparam logic [7:0] ID_HOLDING = 8'h02;
  localparam logic [7:0] ID_MODEM = 8'h00;
  // serial timing: sixteen enables per bit, start + 8 data + stop
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;
  localparam logic [3:0] FRAME_LAST_BIT = 4'h9;
  localparam int SYNC_WIDTH = 5;

  typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_type;
endpackage : uart_mcsb_pkg

// *** pin_sync.sv ***
`timescale 1ns/1ps
module pin_sync
  import uart_mcsb_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // asynchronous pins and their synchronised copies
  input wire logic [SYNC_WIDTH-1:0] pins,
  output logic [SYNC_WIDTH-1:0] pins_sync
);
  import uart_mcsb_pkg::*;

  logic [SYNC_WIDTH-1:0] stage1;
  logic [SYNC_WIDTH-1:0] next_stage1;
  logic [SYNC_WIDTH-1:0] next_pins_sync;

  // idle level of every pin is high, so reset there to avoid a false edge
  always_comb begin
    next_stage1 = pins;
    next_pins_sync = stage1;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      stage1 <= '1;
      pins_sync <= '1;
    end else begin
      stage1 <= next_stage1;
      pins_sync <= next_pins_sync;
    end
  end
endmodule : pin_sync

// *** baud_gen.sv ***
`timescale 1ns/1ps
module baud_gen
  import uart_mcsb_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // divisor and its reload request
  input wire logic [15:0] divisor,
  input wire logic reload,
  // sixteen-times enable
  output logic tick
);
  import uart_mcsb_pkg::*;

  logic [15:0] count;
  logic [15:0] next_count;
  logic next_tick;

  // a zero divisor holds the generator still
  always_comb begin
    next_count = count;
    next_tick = 1'b0;
    if (reload || divisor == 16'h0000) begin
      next_count = divisor; // R20
    end else if (count <= 16'h0001) begin
      next_count = divisor; // R25
      next_tick = 1'b1; // R19
    end else begin
      next_count = count - 16'h0001; // R25
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      count <= DIVISOR_RESET;
      tick <= 1'b0;
    end else begin
      count <= next_count;
      tick <= next_tick;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  AST_TICK_PERIOD: assert property ( // R19
    (tick && divisor == 16'h0003 && !reload) ##1 (!reload) [*2]
      |-> !tick ##1 tick)
    else $error("tick spacing does not match divisor");
  AST_RELOAD: assert property ( // R20
    (reload && divisor != 16'h0000) |=> count == $past(divisor) && !tick)
    else $error("counter not reloaded on divisor write");
endmodule : baud_gen

// *** uart_modem_ctrl_status_baud.sv ***
`timescale 1ns/1ps
// Operation
// R1 - holding-empty sets on transfer to shifter, clears on holding write only
// R2 - enabled holding-empty interrupt; identification read clears it
// R3 - all-empty high only when holding and shifter empty; load clears it
// R4 - line status bit 7 always reads zero
// R5 - modem control readable; bits 0-3 drive pins inverted
// R6 - loopback: serial output marks, input ignored, shifter fed to receiver
// R7 - loopback: modem inputs cut, controls looped inside, pins held high
// R8 - loopback: CTS from RTS, DSR from DTR, RI from user one, DCD from two
// R9 - loopback: modem interrupt sourced from control bits, still enabled
// R10 - modem control bits 5-7 read zero
// R11 - modem status bits 4-7 follow inverted pins; reads leave them
// R12 - delta bits set on change since last read; read clears all
// R13 - ring edge bit sets only on ring pin rising
// R14 - enabled modem interrupt raised by any delta, lowest priority
// R15 - modem status bits follow pins regardless of interrupt enables
// R16 - change during read: dropped if delta set, recorded after if clear
// R17 - status conditions during a read set only at its trailing edge
// R18 - set bit recurring during a read clears at trailing edge
// R19 - divisor 1..65535 yields sixteen-times sample enable
// R20 - writing either divisor byte reloads the baud counter
// R21 - low divisor byte holds divisor bits 0-7
// R22 - host programs both divisor bytes before transfers start
// R23 - divisor bytes reachable only with the divisor access bit set
// R24 - high divisor byte holds divisor bits 8-15
// R25 - counter decrements, pulses at terminal count, then reloads
// R26 - modem pins synchronised before edge detection
module uart_modem_ctrl_status_baud
  import uart_mcsb_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // cpu register port
  input wire logic chip_select,
  input wire logic [2:0] addr,
  input wire logic read_strobe,
  input wire logic write_strobe,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  output logic interrupt_output,
  // serial lines
  input wire logic serial_input,
  output logic serial_output,
  output logic rx_serial_data,
  output logic sample_enable,
  // modem lines, active low
  input wire logic cts_b,
  input wire logic dsr_b,
  input wire logic ri_b,
  input wire logic dcd_b,
  output logic dtr_b,
  output logic rts_b,
  output logic user_output_one_b,
  output logic user_output_two_b
);
  import uart_mcsb_pkg::*;

  function automatic logic hit(input logic [2:0] a, input logic [2:0] sel,
                               input logic divisor_access_bit_need, input logic divisor_access_bit);
    hit = (a == sel) && (divisor_access_bit == divisor_access_bit_need);
  endfunction : hit

  // synchronised pins: [4] serial input, [3] dcd, [2] ri, [1] dsr, [0] cts
  logic [SYNC_WIDTH-1:0] pins_sync;
  logic baud_tick;

  pin_sync u_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .pins({serial_input, dcd_b, ri_b, dsr_b, cts_b}),
    .pins_sync(pins_sync) // R26
  );

  // host registers
  logic [3:0] int_en;
  logic [7:0] lcr;
  logic [4:0] ctrl;
  logic [7:0] scr;
  logic [15:0] divisor;
  logic div_load;
  logic [7:0] holding;
  logic hold_full;
  logic hold_empty;
  logic empty_pend;
  logic empty_ip;
  logic [3:0] delta;
  logic [3:0] delta_pend;
  logic [3:0] status_prev;
  logic rd_prev;
  logic [2:0] rd_addr;
  logic wr_prev;
  logic [7:0] id_at_read;
  logic [3:0] next_int_en;
  logic [7:0] next_lcr;
  logic [4:0] next_ctrl;
  logic [7:0] next_scr;
  logic [15:0] next_divisor;
  logic next_div_load;
  logic [7:0] next_holding;
  logic next_hold_full;
  logic next_hold_empty;
  logic next_empty_pend;
  logic next_empty_ip;
  logic [3:0] next_delta;
  logic [3:0] next_delta_pend;
  logic [3:0] next_status_prev;
  logic next_rd_prev;
  logic [2:0] next_rd_addr;
  logic next_wr_prev;
  logic [7:0] next_id_at_read;
  logic [7:0] next_rdata;
  logic next_interrupt_output;

  // transmitter
  tx_state_type tx_state;
  tx_state_type next_tx_state;
  logic [9:0] shifter;
  logic [9:0] next_shifter;
  logic [3:0] sub_count;
  logic [3:0] next_sub_count;
  logic [3:0] bit_count;
  logic [3:0] next_bit_count;

  // pins
  logic next_serial_output;
  logic next_rx_serial_data;
  logic next_dtr_b;
  logic next_rts_b;
  logic next_user_one_b;
  logic next_user_two_b;

  // decoded strobes and derived state
  logic div_access;
  logic loop;
  logic rd_active;
  logic rd_trail;
  logic wr_pulse;
  logic wr_hold;
  logic xfer;
  logic all_empty;
  logic line_reading;
  logic modem_reading;
  logic [3:0] status;
  logic [3:0] change;
  logic hold_int;
  logic modem_int;
  logic [7:0] id_val;
  logic [7:0] read_val;

  assign div_access = lcr[DIV_ACCESS_BIT];
  assign loop = ctrl[CTRL_LOOP_BIT];
  assign rd_active = chip_select && read_strobe;
  assign rd_trail = rd_prev && !rd_active;
  assign wr_pulse = chip_select && write_strobe && !wr_prev;
  assign wr_hold = wr_pulse && hit(addr, ADDR_HOLD, 1'b0, div_access);
  assign xfer = hold_full && tx_state == TX_IDLE;
  assign all_empty = hold_empty && !hold_full && tx_state == TX_IDLE; // R3
  assign line_reading = rd_active && addr == ADDR_LINE_STATUS;
  assign modem_reading = rd_active && addr == ADDR_MODEM_STATUS;
  // loopback feeds control bits in place of the pins
  assign status = loop ? {ctrl[CTRL_USER_TWO_BIT], // R8
                          ctrl[CTRL_USER_ONE_BIT],
                          ctrl[CTRL_DTR_BIT], ctrl[CTRL_RTS_BIT]}
                       : ~pins_sync[3:0]; // R7 R11 R15
  // ring edge: pin low to high is status one to zero
  assign change = {status[3] != status_prev[3],
                   status_prev[RING_BIT] && !status[RING_BIT], // R13
                   status[1] != status_prev[1],
                   status[0] != status_prev[0]}; // R12
  assign hold_int = int_en[EN_HOLDING_BIT] && empty_ip; // R2
  assign modem_int = int_en[EN_MODEM_BIT] && (|delta); // R9 R14
  assign id_val = hold_int ? ID_HOLDING : (modem_int ? ID_MODEM : ID_NONE);

  always_comb begin
    read_val = 8'h00;
    case (addr)
      ADDR_HOLD: read_val = div_access ? divisor[7:0] : 8'h00; // R21
      ADDR_INT_ENABLE: begin
        read_val = div_access ? divisor[15:8] : {4'h0, int_en}; // R24
      end
      ADDR_INT_ID: read_val = id_val;
      ADDR_LCR: read_val = lcr;
      ADDR_MODEM_CONTROL: read_val = {3'h0, ctrl}; // R5 R10
      ADDR_LINE_STATUS: begin
        read_val = {1'b0, all_empty, hold_empty, 5'h00}; // R4
      end
      ADDR_MODEM_STATUS: read_val = {status, delta};
      ADDR_SCR: read_val = scr;
      default: read_val = 8'h00;
    endcase
  end

  always_comb begin
    next_int_en = int_en;
    next_lcr = lcr;
    next_ctrl = ctrl;
    next_scr = scr;
    next_divisor = divisor;
    next_div_load = 1'b0;
    next_holding = holding;
    next_rd_prev = rd_active;
    next_wr_prev = chip_select && write_strobe;
    next_rd_addr = rd_active ? addr : rd_addr;
    next_rdata = rdata;
    next_id_at_read = id_at_read;
    next_status_prev = status;
    if (rd_active && !rd_prev) begin
      next_rdata = read_val;
      next_id_at_read = id_val;
    end
    if (wr_pulse) begin
      if (hit(addr, ADDR_DIV_LOW, 1'b1, div_access)) begin // R23
        next_divisor[7:0] = wdata; // R21
        next_div_load = 1'b1; // R20
      end
      if (hit(addr, ADDR_DIV_HIGH, 1'b1, div_access)) begin // R23
        next_divisor[15:8] = wdata; // R24
        next_div_load = 1'b1; // R20
      end
      if (hit(addr, ADDR_HOLD, 1'b0, div_access)) begin
        next_holding = wdata;
      end
      if (hit(addr, ADDR_INT_ENABLE, 1'b0, div_access)) begin
        next_int_en = wdata[3:0];
      end
      if (addr == ADDR_LCR) begin
        next_lcr = wdata;
      end
      if (addr == ADDR_MODEM_CONTROL) begin
        next_ctrl = wdata[4:0]; // R5
      end
      if (addr == ADDR_SCR) begin
        next_scr = wdata;
      end
    end
    // a write in the same cycle as a transfer keeps the holding reg full
    next_hold_full = wr_hold || (hold_full && !xfer);
    // holding-empty is a level set by transfer, held off during a line status read
    next_hold_empty = hold_empty;
    next_empty_pend = empty_pend;
    if (wr_hold) begin
      next_hold_empty = 1'b0; // R1
      next_empty_pend = 1'b0;
    end else if (xfer && line_reading) begin
      next_empty_pend = 1'b1; // R17
    end else if (xfer) begin
      next_hold_empty = 1'b1; // R1
    end else if (rd_trail && rd_addr == ADDR_LINE_STATUS && empty_pend) begin
      next_hold_empty = 1'b1; // R17
      next_empty_pend = 1'b0;
    end
    next_empty_ip = empty_ip;
    if (rd_trail && rd_addr == ADDR_INT_ID && id_at_read == ID_HOLDING) begin
      next_empty_ip = 1'b0; // R2
    end
    if (wr_hold) begin
      next_empty_ip = 1'b0;
    end
    if (next_hold_empty && !hold_empty) begin
      next_empty_ip = 1'b1;
    end
    // deltas: changes inside a status read wait for its trailing edge
    next_delta = delta;
    next_delta_pend = delta_pend;
    if (modem_reading) begin
      next_delta_pend = delta_pend | (change & ~delta); // R16
    end else if (rd_trail && rd_addr == ADDR_MODEM_STATUS) begin
      next_delta = delta_pend | change; // R12 R16 R18
      next_delta_pend = 4'h0;
    end else begin
      next_delta = delta | change; // R12
    end
    next_interrupt_output = hold_int || modem_int; // R2 R14
    if (rd_trail && rd_addr == ADDR_INT_ID && id_at_read == ID_HOLDING) begin
      next_interrupt_output = modem_int; // R2
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      int_en <= INT_EN_RESET;
      lcr <= LCR_RESET;
      ctrl <= CTRL_RESET;
      scr <= SCR_RESET;
      divisor <= DIVISOR_RESET;
      div_load <= 1'b0;
      holding <= 8'h00;
      hold_full <= 1'b0;
      hold_empty <= 1'b1;
      empty_pend <= 1'b0;
      empty_ip <= 1'b0;
      delta <= 4'h0;
      delta_pend <= 4'h0;
      status_prev <= 4'h0;
      rd_prev <= 1'b0;
      rd_addr <= 3'h0;
      wr_prev <= 1'b0;
      id_at_read <= ID_NONE;
      rdata <= 8'h00;
      interrupt_output <= 1'b0;
    end else begin
      int_en <= next_int_en;
      lcr <= next_lcr;
      ctrl <= next_ctrl;
      scr <= next_scr;
      divisor <= next_divisor;
      div_load <= next_div_load;
      holding <= next_holding;
      hold_full <= next_hold_full;
      hold_empty <= next_hold_empty;
      empty_pend <= next_empty_pend;
      empty_ip <= next_empty_ip;
      delta <= next_delta;
      delta_pend <= next_delta_pend;
      status_prev <= next_status_prev;
      rd_prev <= next_rd_prev;
      rd_addr <= next_rd_addr;
      wr_prev <= next_wr_prev;
      id_at_read <= next_id_at_read;
      rdata <= next_rdata;
      interrupt_output <= next_interrupt_output;
    end
  end

  // reload waits one cycle so the counter sees the new divisor byte
  baud_gen u_baud (
    .mclk(mclk),
    .rst_b(rst_b),
    .divisor(divisor),
    .reload(div_load), // R20
    .tick(baud_tick) // R19
  );

  // minimal 8N1 shifter: enough to time holding and shifter empty flags
  always_comb begin
    next_tx_state = tx_state;
    next_shifter = shifter;
    next_sub_count = sub_count;
    next_bit_count = bit_count;
    case (tx_state)
      TX_IDLE: begin
        if (xfer) begin
          next_shifter = {1'b1, holding, 1'b0}; // R1
          next_sub_count = 4'h0;
          next_bit_count = 4'h0;
          next_tx_state = TX_SHIFT;
        end
      end
      TX_SHIFT: begin
        if (baud_tick) begin
          next_sub_count = sub_count + 4'h1;
          if (sub_count == OVERSAMPLE_LAST) begin
            next_shifter = {1'b1, shifter[9:1]};
            next_bit_count = bit_count + 4'h1;
            if (bit_count == FRAME_LAST_BIT) begin
              next_tx_state = TX_IDLE; // R3
            end
          end
        end
      end
      default: next_tx_state = TX_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tx_state <= TX_IDLE;
      shifter <= 10'h3FF;
      sub_count <= 4'h0;
      bit_count <= 4'h0;
    end else begin
      tx_state <= next_tx_state;
      shifter <= next_shifter;
      sub_count <= next_sub_count;
      bit_count <= next_bit_count;
    end
  end

  // output pins, all registered
  always_comb begin
    next_serial_output = loop ? 1'b1 : shifter[0]; // R6
    next_rx_serial_data = loop ? shifter[0] : pins_sync[4]; // R6
    next_dtr_b = loop || !ctrl[CTRL_DTR_BIT]; // R5 R7
    next_rts_b = loop || !ctrl[CTRL_RTS_BIT]; // R5 R7
    next_user_one_b = loop || !ctrl[CTRL_USER_ONE_BIT]; // R5 R7
    next_user_two_b = loop || !ctrl[CTRL_USER_TWO_BIT]; // R5 R7
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      serial_output <= 1'b1;
      rx_serial_data <= 1'b1;
      sample_enable <= 1'b0;
      dtr_b <= 1'b1;
      rts_b <= 1'b1;
      user_output_one_b <= 1'b1;
      user_output_two_b <= 1'b1;
    end else begin
      serial_output <= next_serial_output;
      rx_serial_data <= next_rx_serial_data;
      sample_enable <= baud_tick; // R19
      dtr_b <= next_dtr_b;
      rts_b <= next_rts_b;
      user_output_one_b <= next_user_one_b;
      user_output_two_b <= next_user_two_b;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence holding_write;
    wr_hold && !xfer;
  endsequence

  AST_EMPTY_WRITE: assert property (holding_write |=> !hold_empty) // R1
    else $error("holding-empty not cleared by holding write");
  AST_EMPTY_XFER: assert property ( // R1
    (xfer && !wr_hold && !line_reading) |=> hold_empty)
    else $error("holding-empty not set on transfer");
  AST_ALL_EMPTY_LOAD: assert property ( // R3
    holding_write |=> !all_empty ##1 !all_empty)
    else $error("all-empty not low after load");
  AST_LINE_TOP: assert property ( // R4
    $rose(rd_prev) && rd_addr == ADDR_LINE_STATUS |-> !rdata[7])
    else $error("line status bit 7 reads one");
  AST_LOOP_RX: assert property ( // R6
    loop |=> rx_serial_data == $past(shifter[0]))
    else $error("loopback receive data not fed from shifter");
  AST_LOOP_PINS: assert property ( // R7
    loop |=> dtr_b && rts_b && user_output_one_b && user_output_two_b
             && serial_output)
    else $error("pins not inactive in loopback");
  AST_CONTROL_PIN: assert property ( // R5
    !loop && !$changed(ctrl) |=> dtr_b == !$past(ctrl[CTRL_DTR_BIT]))
    else $error("dtr pin not inverse of control bit");
  AST_STATUS_CLEAR: assert property ( // R12
    (rd_trail && rd_addr == ADDR_MODEM_STATUS && delta_pend == 4'h0
     && change == 4'h0) |=> delta == 4'h0)
    else $error("delta bits not cleared by status read");
  AST_DEFER: assert property ( // R17
    (modem_reading && |(change & ~delta)) |=> $stable(delta))
    else $error("delta set inside a status read");
  AST_MODEM_INT: assert property ( // R14
    (int_en[EN_MODEM_BIT] && |delta && !rd_trail) |=> interrupt_output)
    else $error("modem interrupt not raised");
  AST_RI_FALL: assert property ( // R13
    (!modem_reading && !rd_trail && !delta[RING_BIT]
     && !status_prev[RING_BIT] && status[RING_BIT])
      |=> !delta[RING_BIT])
    else $error("ring edge set on wrong direction");
endmodule : uart_modem_ctrl_status_baud

// *** modem_model.sv ***
`timescale 1ns/1ps
module modem_model (
  // lines from the uart, active low
  input wire logic dtr_b,
  input wire logic rts_b,
  input wire logic user_output_one_b,
  input wire logic user_output_two_b,
  input wire logic serial_output,
  // lines to the uart, active low
  output logic cts_b,
  output logic dsr_b,
  output logic ri_b,
  output logic dcd_b,
  output logic serial_input
);
  // an idle data set holds every line high and the data line marking
  initial begin
    cts_b = 1'b1;
    dsr_b = 1'b1;
    ri_b = 1'b1;
    dcd_b = 1'b1;
    serial_input = 1'b1;
  end

  // order is {carrier, ring, set ready, clear to send}; call off the edge
  task set_lines(input logic [3:0] v);
    {dcd_b, ri_b, dsr_b, cts_b} = v;
  endtask : set_lines
endmodule : modem_model

// *** uart_modem_ctrl_status_baud_tb_top.sv ***
`timescale 1ns/1ps
module uart_modem_ctrl_status_baud_tb_top;
  import uart_mcsb_pkg::*;
  logic mclk, rst_b, cs, rs, ws, serial_input, serial_output;
  logic sample_enable, irq, cts_b, dsr_b, ri_b, dcd_b;
  logic dtr_b, rts_b, o1_b, o2_b;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, d;
  int mismatches, checks, cycles, n;

  uart_modem_ctrl_status_baud uart_modem_ctrl_status_baud_inst (
    .mclk(mclk), .rst_b(rst_b), .chip_select(cs), .addr(addr),
    .read_strobe(rs), .write_strobe(ws), .wdata(wdata), .rdata(rdata),
    .interrupt_output(irq), .serial_input(serial_input),
    .serial_output(serial_output), .rx_serial_data(),
    .sample_enable(sample_enable), .cts_b(cts_b), .dsr_b(dsr_b),
    .ri_b(ri_b), .dcd_b(dcd_b), .dtr_b(dtr_b), .rts_b(rts_b),
    .user_output_one_b(o1_b), .user_output_two_b(o2_b));

  modem_model modem_model_inst (
    .dtr_b(dtr_b), .rts_b(rts_b), .user_output_one_b(o1_b),
    .user_output_two_b(o2_b), .serial_output(serial_output),
    .cts_b(cts_b), .dsr_b(dsr_b), .ri_b(ri_b), .dcd_b(dcd_b),
    .serial_input(serial_input));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // whole run is near 1400 cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  task check(input string name, input logic [7:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // every access starts on its own falling edge, so strobes drop a cycle
  task wr(input logic [2:0] a, input logic [7:0] v);
    @(negedge mclk);
    cs = 1'b1;
    ws = 1'b1;
    addr = a;
    wdata = v;
    @(negedge mclk);
    ws = 1'b0;
    cs = 1'b0;
  endtask : wr

  task rd(input logic [2:0] a, input int len, output logic [7:0] v);
    @(negedge mclk);
    cs = 1'b1;
    rs = 1'b1;
    addr = a;
    repeat (len) @(negedge mclk);
    v = rdata;
    rs = 1'b0;
    cs = 1'b0;
    @(negedge mclk);
  endtask : rd

  task rc(input string name, input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, 2, v);
    check(name, v, exp);
  endtask : rc

  task idle(input int k);
    repeat (k) @(negedge mclk);
  endtask : idle

  task tally_and_finish();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    {cs, rs, ws, addr, wdata, rst_b} = '0;
    {mismatches, checks, cycles, n} = '0;
    repeat (2) @(negedge mclk);
    rst_b = 1'b1;
    rc("line_reset", ADDR_LINE_STATUS, 8'h60);
    rc("status_reset", ADDR_MODEM_STATUS, 8'h00);
    rc("control_reset", ADDR_MODEM_CONTROL, 8'h00);
    wr(ADDR_MODEM_CONTROL, 8'h0F);
    idle(2);
    check("pins_on", {4'h0, dtr_b, rts_b, o1_b, o2_b}, 8'h00);
    rc("control_rw", ADDR_MODEM_CONTROL, 8'h0F);
    wr(ADDR_MODEM_CONTROL, 8'hFF);
    idle(5);
    rc("control_top", ADDR_MODEM_CONTROL, 8'h1F);
    check("loop_pins", {3'h0, serial_output, dtr_b, rts_b, o1_b, o2_b},
          8'h1F);
    rc("loop_status", ADDR_MODEM_STATUS, 8'hFB);
    rc("delta_clear", ADDR_MODEM_STATUS, 8'hF0);
    wr(ADDR_MODEM_CONTROL, 8'h10);
    modem_model_inst.set_lines(4'hE);
    idle(5);
    rc("loop_ring", ADDR_MODEM_STATUS, 8'h0F);
    wr(ADDR_MODEM_CONTROL, 8'h00);
    idle(5);
    rc("pin_status", ADDR_MODEM_STATUS, 8'h11);
    rc("status_kept", ADDR_MODEM_STATUS, 8'h10);
    $display("test modem lines done");
    wr(ADDR_INT_ENABLE, 8'h08);
    modem_model_inst.set_lines(4'hF);
    idle(5);
    check("modem_irq", {7'h0, irq}, 8'h01);
    rc("id_modem", ADDR_INT_ID, 8'h00);
    rc("cts_drop", ADDR_MODEM_STATUS, 8'h01);
    idle(2);
    check("irq_clear", {7'h0, irq}, 8'h00);
    modem_model_inst.set_lines(4'hB);
    idle(5);
    rc("ring_fall", ADDR_MODEM_STATUS, 8'h40);
    modem_model_inst.set_lines(4'hF);
    idle(5);
    rc("ring_rise", ADDR_MODEM_STATUS, 8'h04);
    // carrier detect comes on (dcd_b low) while a long status read is in progress
    fork
      rd(ADDR_MODEM_STATUS, 8, d);
      begin
        idle(3);
        modem_model_inst.set_lines(4'h7);
      end
    join
    check("during_read", d, 8'h00);
    rc("after_read", ADDR_MODEM_STATUS, 8'h88);
    $display("test modem events done");
    wr(ADDR_LCR, 8'h80);
    wr(ADDR_DIV_LOW, 8'h03);
    wr(ADDR_DIV_HIGH, 8'hA5);
    rc("div_high", ADDR_DIV_HIGH, 8'hA5);
    wr(ADDR_DIV_HIGH, 8'h00);
    rc("div_low", ADDR_DIV_LOW, 8'h03);
    wr(ADDR_LCR, 8'h00);
    rc("enable_back", ADDR_INT_ENABLE, 8'h08);
    for (int i = 0; i < 30; i++) begin
      @(negedge mclk);
      n += int'(sample_enable);
    end
    check("ticks", n[7:0], 8'h0A);
    $display("test baud done");
    wr(ADDR_INT_ENABLE, 8'h02);
    wr(ADDR_HOLD, 8'h55);
    idle(3);
    wr(ADDR_HOLD, 8'hA3);
    rc("line_loaded", ADDR_LINE_STATUS, 8'h00);
    idle(600);
    rc("holding_moved", ADDR_LINE_STATUS, 8'h20);
    check("holding_irq", {7'h0, irq}, 8'h01);
    rc("id_holding", ADDR_INT_ID, 8'h02);
    idle(2);
    check("holding_irq_read", {7'h0, irq}, 8'h00);
    idle(600);
    rc("all_empty", ADDR_LINE_STATUS, 8'h60);
    $display("test transmit done");
    tally_and_finish();
  end
endmodule : uart_modem_ctrl_status_baud_tb_top
